// ===== rtl/ispo_pkg.sv
// Shared constants and types for the image sensor pixel output block
package ispo_pkg;
    localparam int PIX_W     = 12;
    localparam int CNT_W     = 16;
    localparam int TMR_W     = 24;
    localparam int GAIN_W    = 8;
    localparam int GAIN_FRAC = 5;
    localparam int NLANE     = 4;
    localparam int NLANE_DUAL = 2;
    localparam logic [PIX_W-1:0] PIX_MAX  = 12'hfff;
    localparam logic [7:0]       ADDR_LO  = 8'h20;
    localparam logic [7:0]       ADDR_HI  = 8'h30;
    localparam logic [15:0]      FMT_QUAD = 16'h0304;
    localparam logic [15:0]      FMT_DUAL = 16'h0302;
    localparam int MCLK_MIN_KHZ = 6000;
    localparam int MCLK_MAX_KHZ = 50000;
    localparam int PCLK_MAX_KHZ = 74250;
    localparam int PIX_MAX_KPS  = 148500;
    localparam int HS_CYCLES    = 32;

    typedef struct packed {
        logic             fr_first;
        logic             fr_last;
        logic             ln_last;
        logic [PIX_W-1:0] data;
    } ispo_word_t;

    typedef struct packed {
        logic par_en;
        logic ser_dis;
        logic drive;
        logic quad;
    } ispo_lcfg_t;

    localparam ispo_lcfg_t LCFG_RST = 4'h1;
endpackage

// ===== rtl/ispo_ser.sv
// Multi-lane serializer with DDR clock lane, MSB first
module ispo_ser #(
    parameter int W = 12,
    parameter int N = 4
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         quad,
    input  wire logic         in_valid,
    input  wire logic [W-1:0] in_data,
    output logic              in_ready,
    output logic [N-1:0]      lane_p,
    output logic [N-1:0]      lane_n,
    output logic              dclk_p,
    output logic              dclk_n
);
    initial begin
        if (N < ispo_pkg::NLANE_DUAL || W < 2)
            $error("ispo_ser: unsupported lane count or width");
    end

    logic [W-1:0] sh_r [N];
    logic [7:0]   fill_r;
    logic [7:0]   bit_r;
    logic         busy_r;
    logic [N-1:0] lp_nxt;
    logic [N-1:0] lact;
    wire  [7:0]   nl = quad ? 8'(N) : 8'(ispo_pkg::NLANE_DUAL);
    // Greater-or-equal so a lane-count change never strands the fill count
    wire          full = (fill_r >= nl - 8'h01);
    wire          load = in_valid && !busy_r;

    assign in_ready = !busy_r;

    always_comb begin
        for (int i = 0; i < N; i++) begin
            lact[i]   = busy_r && (8'(i) < nl);
            lp_nxt[i] = lact[i] && sh_r[i][W-1];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < N; i++)
                sh_r[i] <= '0;
            fill_r <= '0;
            bit_r  <= '0;
            busy_r <= 1'b0;
            lane_p <= '0;
            lane_n <= '0;
            dclk_p <= 1'b0;
            dclk_n <= 1'b0;
        end else begin
            lane_p <= lp_nxt;
            lane_n <= lact & ~lp_nxt;
            dclk_p <= busy_r ? ~dclk_p : 1'b0;
            dclk_n <= busy_r ? dclk_p : 1'b0;
            if (load) begin
                sh_r[fill_r[$clog2(N)-1:0]] <= in_data;
                busy_r <= full;
                fill_r <= full ? 8'h00 : fill_r + 8'h01;
                bit_r  <= '0;
            end else if (busy_r) begin
                for (int i = 0; i < N; i++)
                    sh_r[i] <= sh_r[i] << 1;
                bit_r  <= bit_r + 8'h01;
                busy_r <= (bit_r != 8'(W - 1));
            end
        end
    end

    a_ser_msb: assert property (@(posedge clk) disable iff (!rst_n)
        (busy_r && bit_r == 8'h00) |=> lane_p[0] == $past(sh_r[0][W-1]))
        else $error("lane 0 did not start with the word MSB");
    a_dual_idle: assert property (@(posedge clk) disable iff (!rst_n)
        (!quad) [*2] |-> lane_p[N-1:ispo_pkg::NLANE_DUAL] == '0)
        else $error("upper lanes active in dual-lane format");
endmodule

// ===== rtl/ispo_top.sv
// Rolling-shutter readout sequencer and pixel output ports
// Functional notes
// - Frames repeat progressively at fixed frame period
// - Rows reset then read in consecutive order
// - Exposure equals programmed reset-to-read row gap, capped at FRAME_ROWS - ROWS
// - Column values get offset, analog gain first
// - Converter yields one 12-bit value per pixel
// - Digital chain applies correction and digital gain
// - Clocks from one 6-50 MHz reference
// - Pixel rate at most 148.5 Mp/s
// - All configuration arrives over two-wire bus; here settings come in on input ports
// - Bus address 0x20 or 0x30 by select
// - Parallel data valid at pixel clock rise
// - Row-valid only while data is valid
// - Frame-valid spans valid frame data
// - 12-bit bus, bit 11 is MSB
// - Async active-low reset restores all defaults
// - Four serial lanes plus DDR clock lane
// - Parallel port off until host enables it
// - Format 0x0304 four lanes, 0x0302 two
module ispo_top #(
    parameter int COLS       = 1280,
    parameter int ROWS       = 800,
    parameter int FRAME_ROWS = 850,
    parameter int ROW_CYCLES = 40960,
    parameter int MCLK_KHZ   = 24000,
    parameter int LINK_KHZ   = 31250
) (
    input  wire logic                         clk,
    input  wire logic                         rst_n,
    input  wire logic                         link_clk,
    input  wire logic [ispo_pkg::PIX_W-1:0]   array_sample,
    input  wire logic [ispo_pkg::CNT_W-1:0]   exposure_rows,
    input  wire logic [ispo_pkg::PIX_W-1:0]   ana_offset,
    input  wire logic [ispo_pkg::GAIN_W-1:0]  ana_gain,
    input  wire logic [ispo_pkg::PIX_W-1:0]   dig_pedestal,
    input  wire logic [ispo_pkg::GAIN_W-1:0]  dig_gain,
    input  wire logic                         par_enable,
    input  wire logic                         ser_disable,
    input  wire logic                         drive_pins,
    input  wire logic [15:0]                  serial_format,
    input  wire logic                         high_common_mode_sel,
    input  wire logic                         trig_mode,
    input  wire logic                         trigger_pin,
    input  wire logic                         standby_pin,
    input  wire logic                         out_en_n_pin,
    input  wire logic                         bus_addr_select,
    input  wire logic [7:0]                   bus_addr_byte,
    input  wire logic                         bus_addr_stb,
    output logic                              bus_addr_hit,
    output logic                              row_reset_stb,
    output logic [ispo_pkg::CNT_W-1:0]        row_reset_addr,
    output logic                              row_read_stb,
    output logic [ispo_pkg::CNT_W-1:0]        row_read_addr,
    output logic [ispo_pkg::CNT_W-1:0]        col_addr,
    output logic                              flash_strobe,
    output logic                              ser_high_cm,
    output logic                              pixel_out_clock,
    output logic [ispo_pkg::PIX_W-1:0]        dout,
    output logic                              line_valid,
    output logic                              frame_valid,
    output logic                              par_oe,
    output logic [ispo_pkg::NLANE-1:0]        lane_p,
    output logic [ispo_pkg::NLANE-1:0]        lane_n,
    output logic                              serial_ddr_clock_lane_p,
    output logic                              serial_ddr_clock_lane_n
);
    localparam int PW = ispo_pkg::PIX_W;
    localparam int CW = ispo_pkg::CNT_W;
    localparam int TW = ispo_pkg::TMR_W;
    typedef ispo_pkg::ispo_word_t ispo_word_t;
    typedef ispo_pkg::ispo_lcfg_t ispo_lcfg_t;
    localparam logic [CW-1:0] ROWS_C = CW'(ROWS);
    localparam logic [CW-1:0] COL_LAST = CW'(COLS - 1);
    localparam logic [CW-1:0] FR_LAST = CW'(FRAME_ROWS - 1);
    localparam logic [CW-1:0] EXP_MAX = CW'(FRAME_ROWS - ROWS);
    localparam logic [TW-1:0] TMR_LAST = TW'(ROW_CYCLES - 1);

    initial begin
        if (MCLK_KHZ < ispo_pkg::MCLK_MIN_KHZ ||
            MCLK_KHZ > ispo_pkg::MCLK_MAX_KHZ)
            $error("reference clock outside allowed range");
        if (LINK_KHZ / 2 > ispo_pkg::PCLK_MAX_KHZ ||
            LINK_KHZ > ispo_pkg::PIX_MAX_KPS)
            $error("link clock exceeds pixel rate limit");
        if (FRAME_ROWS <= ROWS || FRAME_ROWS >= 2**CW || COLS < 1 ||
            ROW_CYCLES < COLS * ispo_pkg::HS_CYCLES ||
            ROW_CYCLES >= 2**TW)
            $error("ispo_top: unsupported geometry");
    end

    function automatic logic [PW-1:0] scale(
        input logic [PW-1:0] v, input logic [PW-1:0] off,
        input logic [ispo_pkg::GAIN_W-1:0] g);
        logic [PW-1:0] d;
        logic [PW+ispo_pkg::GAIN_W-1:0] p;
        logic [PW+ispo_pkg::GAIN_W-ispo_pkg::GAIN_FRAC-1:0] s;
        d = (v > off) ? v - off : '0;
        p = d * g;
        s = p[PW+ispo_pkg::GAIN_W-1:ispo_pkg::GAIN_FRAC];
        scale = (s > {{(ispo_pkg::GAIN_W-ispo_pkg::GAIN_FRAC){1'b0}},
                      ispo_pkg::PIX_MAX}) ? ispo_pkg::PIX_MAX : s[PW-1:0];
    endfunction

    typedef enum logic [0:0] {ST_IDLE, ST_RUN} ispo_fst_t;
    typedef enum logic [1:0] {W_IDLE, W_ADDR, W_CONV, W_WAIT} ispo_wst_t;

    // Core clock domain
    ispo_fst_t           st_r;
    ispo_wst_t           ws_r;
    logic [CW-1:0]       fr_row_r;
    logic [TW-1:0]       tmr_r;
    logic [CW-1:0]       col_r;
    logic                rd_first_r, rd_last_r;
    logic                stby_s1_r, stby_s2_r;
    logic                trg_s1_r, trg_s2_r, trg_s3_r;
    logic                sel_s1_r, sel_s2_r;
    logic                ack_s1_r, ack_s2_r, ack_t_r;
    logic                req_r;
    ispo_word_t          word_r;
    ispo_lcfg_t          cfg_r;

    wire [CW-1:0] exp_c = (exposure_rows > EXP_MAX) ? EXP_MAX
                                                    : exposure_rows;
    wire [CW-1:0] rd_row = fr_row_r - exp_c;
    wire          run = (st_r == ST_RUN);
    wire          row_start = run && (tmr_r == '0);
    wire          row_end = run && (tmr_r == TMR_LAST);
    wire          fr_end = row_end && (fr_row_r == FR_LAST);
    wire          rst_vld = fr_row_r < ROWS_C;
    wire          rd_vld = (fr_row_r >= exp_c) && (rd_row < ROWS_C);
    wire          trg_edge = trg_s2_r && !trg_s3_r;
    wire          start_ok = !stby_s2_r && (!trig_mode || trg_edge);
    wire          hs_done = (ack_s2_r == req_r);
    wire          col_end = (col_r == COL_LAST);
    wire [PW-1:0] pix_val = scale(scale(array_sample, ana_offset,
                                        ana_gain), dig_pedestal, dig_gain);
    wire [7:0]    my_addr = sel_s2_r ? ispo_pkg::ADDR_HI : ispo_pkg::ADDR_LO;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stby_s1_r <= 1'b0;
            stby_s2_r <= 1'b0;
            trg_s1_r  <= 1'b0;
            trg_s2_r  <= 1'b0;
            trg_s3_r  <= 1'b0;
            sel_s1_r  <= 1'b0;
            sel_s2_r  <= 1'b0;
            ack_s1_r  <= 1'b0;
            ack_s2_r  <= 1'b0;
        end else begin
            stby_s1_r <= standby_pin;
            stby_s2_r <= stby_s1_r;
            trg_s1_r  <= trigger_pin;
            trg_s2_r  <= trg_s1_r;
            trg_s3_r  <= trg_s2_r;
            sel_s1_r  <= bus_addr_select;
            sel_s2_r  <= sel_s1_r;
            ack_s1_r  <= ack_t_r;
            ack_s2_r  <= ack_s1_r;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r     <= ST_IDLE;
            fr_row_r <= '0;
            tmr_r    <= '0;
        end else if (!run) begin
            tmr_r    <= '0;
            fr_row_r <= '0;
            if (start_ok)
                st_r <= ST_RUN;
        end else if (row_end) begin
            tmr_r    <= '0;
            fr_row_r <= fr_end ? '0 : fr_row_r + 1'b1;
            if (fr_end && !start_ok)
                st_r <= ST_IDLE;
        end else begin
            tmr_r <= tmr_r + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            row_reset_stb  <= 1'b0;
            row_reset_addr <= '0;
            row_read_stb   <= 1'b0;
            row_read_addr  <= '0;
            flash_strobe   <= 1'b0;
            bus_addr_hit   <= 1'b0;
            cfg_r          <= ispo_pkg::LCFG_RST;
            ser_high_cm    <= 1'b0;
        end else begin
            row_reset_stb  <= row_start && rst_vld;
            row_reset_addr <= fr_row_r;
            row_read_stb   <= row_start && rd_vld;
            row_read_addr  <= rd_row;
            flash_strobe   <= run && (fr_row_r < exp_c);
            bus_addr_hit   <= bus_addr_stb &&
                (bus_addr_byte[7:1] == my_addr[7:1]);
            cfg_r <= '{par_en: par_enable, ser_dis: ser_disable,
                       drive: drive_pins,
                       quad: serial_format != ispo_pkg::FMT_DUAL};
            ser_high_cm    <= high_common_mode_sel;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ws_r      <= W_IDLE;
            col_r     <= '0;
            col_addr  <= '0;
            rd_first_r <= 1'b0;
            rd_last_r <= 1'b0;
            req_r     <= 1'b0;
            word_r    <= '0;
        end else begin
            case (ws_r)
                W_IDLE: if (row_start && rd_vld) begin
                    ws_r       <= W_ADDR;
                    col_r      <= '0;
                    rd_first_r <= (rd_row == '0);
                    rd_last_r  <= (rd_row == ROWS_C - 1'b1);
                end
                W_ADDR: begin
                    col_addr <= col_r;
                    ws_r     <= W_CONV;
                end
                W_CONV: begin
                    word_r <= '{fr_first: rd_first_r && col_r == '0,
                                fr_last: rd_last_r && col_end,
                                ln_last: col_end,
                                data: pix_val};
                    req_r  <= !req_r;
                    ws_r   <= W_WAIT;
                end
                W_WAIT: if (hs_done) begin
                    ws_r  <= col_end ? W_IDLE : W_ADDR;
                    col_r <= col_r + 1'b1;
                end
                default: ws_r <= W_IDLE;
            endcase
        end
    end

    // Link clock domain
    logic       lrst_s1_r, lrst_n_r;
    logic       req_s1_r, req_s2_r, req_s3_r;
    logic       oe_s1_r, oe_s2_r;
    ispo_lcfg_t lcfg_s1_r, lcfg_s2_r;
    ispo_word_t hold_r;
    logic       hold_v_r, fv_end_r;
    logic       ser_rdy;

    wire par_act = lcfg_s2_r.par_en && lcfg_s2_r.ser_dis;
    wire ser_act = !lcfg_s2_r.ser_dis;
    wire req_edge = req_s2_r ^ req_s3_r;
    wire par_take = hold_v_r && par_act && pixel_out_clock;
    wire ser_take = hold_v_r && ser_act && ser_rdy;
    wire drop = hold_v_r && !par_act && !ser_act;
    wire take = par_take || ser_take || drop;

    always_ff @(posedge link_clk or negedge rst_n) begin
        if (!rst_n) begin
            lrst_s1_r <= 1'b0;
            lrst_n_r  <= 1'b0;
        end else begin
            lrst_s1_r <= 1'b1;
            lrst_n_r  <= lrst_s1_r;
        end
    end

    always_ff @(posedge link_clk or negedge lrst_n_r) begin
        if (!lrst_n_r) begin
            req_s1_r  <= 1'b0;
            req_s2_r  <= 1'b0;
            req_s3_r  <= 1'b0;
            oe_s1_r   <= 1'b1;
            oe_s2_r   <= 1'b1;
            lcfg_s1_r <= ispo_pkg::LCFG_RST;
            lcfg_s2_r <= ispo_pkg::LCFG_RST;
            hold_r    <= '0;
            hold_v_r  <= 1'b0;
            ack_t_r   <= 1'b0;
        end else begin
            req_s1_r  <= req_r;
            req_s2_r  <= req_s1_r;
            req_s3_r  <= req_s2_r;
            oe_s1_r   <= out_en_n_pin;
            oe_s2_r   <= oe_s1_r;
            lcfg_s1_r <= cfg_r;
            lcfg_s2_r <= lcfg_s1_r;
            if (req_edge)
                hold_r <= word_r;
            hold_v_r  <= req_edge || (hold_v_r && !take);
            ack_t_r   <= ack_t_r ^ take;
        end
    end

    always_ff @(posedge link_clk or negedge lrst_n_r) begin
        if (!lrst_n_r) begin
            pixel_out_clock <= 1'b0;
            dout            <= '0;
            line_valid      <= 1'b0;
            frame_valid     <= 1'b0;
            fv_end_r        <= 1'b0;
            par_oe          <= 1'b0;
        end else begin
            pixel_out_clock <= par_act && !pixel_out_clock;
            par_oe <= par_act && (!oe_s2_r || lcfg_s2_r.drive);
            if (!par_act) begin
                dout        <= '0;
                line_valid  <= 1'b0;
                frame_valid <= 1'b0;
                fv_end_r    <= 1'b0;
            end else if (pixel_out_clock) begin
                if (par_take)
                    dout <= hold_r.data;
                line_valid <= par_take;
                if (par_take && hold_r.fr_first)
                    frame_valid <= 1'b1;
                else if (fv_end_r)
                    frame_valid <= 1'b0;
                fv_end_r <= par_take && hold_r.fr_last;
            end
        end
    end

    ispo_ser #(
        .W (PW),
        .N (ispo_pkg::NLANE)
    ) u_ser (
        .clk      (link_clk),
        .rst_n    (lrst_n_r),
        .quad     (lcfg_s2_r.quad),
        .in_valid (hold_v_r && ser_act),
        .in_data  (hold_r.data),
        .in_ready (ser_rdy),
        .lane_p   (lane_p),
        .lane_n   (lane_n),
        .dclk_p   (serial_ddr_clock_lane_p),
        .dclk_n   (serial_ddr_clock_lane_n)
    );

    sequence s_frame_stop;
        fr_end && stby_s2_r;
    endsequence
    sequence s_par_word;
        par_take ##1 line_valid;
    endsequence

    a_row_order: assert property (@(posedge clk) disable iff (!rst_n)
        (row_end && !fr_end) |=> fr_row_r == $past(fr_row_r) + 1'b1)
        else $error("row counter skipped");
    a_frame_wrap: assert property (@(posedge clk) disable iff (!rst_n)
        (fr_end && !stby_s2_r && !trig_mode) |=> run && fr_row_r == '0)
        else $error("frame did not restart");
    a_exp_gap: assert property (@(posedge clk) disable iff (!rst_n)
        (row_start && rd_vld) |=>
            row_read_stb && row_read_addr == $past(fr_row_r - exp_c))
        else $error("read row not exposure rows behind reset");
    a_conv_word: assert property (@(posedge clk) disable iff (!rst_n)
        (ws_r == W_CONV) |=>
            word_r.data == $past(pix_val) && req_r != $past(req_r))
        else $error("converted pixel not launched");
    a_standby_stop: assert property (@(posedge clk) disable iff (!rst_n)
        s_frame_stop |=> !run ##1 (!run || !$past(stby_s2_r)))
        else $error("standby did not halt at frame end");
    a_flash_exp: assert property (@(posedge clk) disable iff (!rst_n)
        flash_strobe |-> $past(run && fr_row_r < exp_c))
        else $error("strobe outside exposure start");
    a_addr_hit: assert property (@(posedge clk) disable iff (!rst_n)
        (bus_addr_stb && sel_s2_r &&
         bus_addr_byte[7:1] == ispo_pkg::ADDR_HI[7:1]) |=> bus_addr_hit)
        else $error("high bus address not matched");
    a_lv_data: assert property (@(posedge link_clk) disable iff (!lrst_n_r)
        s_par_word |-> dout == $past(hold_r.data))
        else $error("row valid without matching data");
    a_data_stable: assert property (@(posedge link_clk) disable iff (!lrst_n_r)
        $changed(dout) |-> !pixel_out_clock)
        else $error("data changed at pixel clock rise");
    a_fv_span: assert property (@(posedge link_clk) disable iff (!lrst_n_r)
        line_valid |-> frame_valid)
        else $error("row valid outside frame valid");
    a_oe_off: assert property (@(posedge link_clk) disable iff (!lrst_n_r)
        (!par_act) [*2] |-> !par_oe && !line_valid)
        else $error("parallel port driven while disabled");
endmodule

// ===== tb/ispo_rx_model.sv
// Receiver model capturing the parallel pixel stream and checking the serial lanes and clock
module ispo_rx_model (
    input  wire logic        link_clk,
    input  wire logic        pclk,
    input  wire logic [11:0] dout,
    input  wire logic        lv,
    input  wire logic        fv,
    input  wire logic        dual,
    input  wire logic [3:0]  lp,
    input  wire logic [3:0]  ln,
    input  wire logic        ck,
    output int               nw,
    output int               fw,
    output int               bad,
    output int               edges,
    output logic [11:0]      last
);
    timeunit 1ns;
    timeprecision 100ps;
    logic ck_q = 1'b0;
    int   dn = 0;
    always @(posedge pclk) begin
        if (lv) begin
            nw++;
            last = dout;
            if (!fv) bad++;
        end
    end
    always @(negedge fv) begin
        fw = nw;
        nw = 0;
    end
    always @(posedge link_clk) begin
        if (ck !== ck_q) edges++;
        ck_q = ck;
        if ((lp & ln) != 4'h0) bad++;
        // Format change reaches the link side a few cycles late
        dn = dual ? dn + 1 : 0;
        if (dn > 4 && (lp[3:2] | ln[3:2]) != 2'h0) bad++;
    end
endmodule

// ===== tb/ispo_top_test.sv
// Self-checking bench for the pixel output block
module ispo_top_test;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int RC = 512;
    localparam int FR = 8 * RC;
    logic        clk = 1'b0, link_clk = 1'b0, rst_n = 1'b0;
    logic [11:0] smp = 12'h801, aoff = 12'h000, ped = 12'h000;
    logic [7:0]  ag = 8'h20, dg = 8'h20, ab = 8'h00;
    logic [15:0] exr = 16'h0003, fmt = 16'h0304;
    logic        pe = 1'b0, sd = 1'b0, dp = 1'b0, hcm = 1'b0, tm = 1'b0;
    logic        trg = 1'b0, sb = 1'b0, oen = 1'b0, sel = 1'b0, stb = 1'b0;
    logic        hit, rrs, rds, fl, pclk, lv, fv, oe, ckp, ckn, hc;
    logic [15:0] rra, rda, ca;
    logic [11:0] dout;
    logic [3:0]  lp, ln;
    int          n_errors = 0, num_checks = 0, cyc = 0, nres = 0, t0 = 0;
    int          nfl = 0;
    bit          per_on = 1'b0;
    always #2 clk = ~clk;
    initial begin
        #5;
        forever #16 link_clk = ~link_clk;
    end
    ispo_top #(.COLS(8), .ROWS(4), .FRAME_ROWS(8), .ROW_CYCLES(RC)) dut (
        .clk(clk), .rst_n(rst_n), .link_clk(link_clk), .array_sample(smp),
        .exposure_rows(exr), .ana_offset(aoff), .ana_gain(ag),
        .dig_pedestal(ped), .dig_gain(dg), .par_enable(pe),
        .ser_disable(sd), .drive_pins(dp), .serial_format(fmt),
        .high_common_mode_sel(hcm), .trig_mode(tm), .trigger_pin(trg),
        .standby_pin(sb), .out_en_n_pin(oen), .bus_addr_select(sel),
        .bus_addr_byte(ab), .bus_addr_stb(stb), .bus_addr_hit(hit),
        .row_reset_stb(rrs), .row_reset_addr(rra), .row_read_stb(rds),
        .row_read_addr(rda), .col_addr(ca), .flash_strobe(fl),
        .ser_high_cm(hc), .pixel_out_clock(pclk), .dout(dout),
        .line_valid(lv), .frame_valid(fv), .par_oe(oe), .lane_p(lp),
        .lane_n(ln), .serial_ddr_clock_lane_p(ckp),
        .serial_ddr_clock_lane_n(ckn));
    ispo_rx_model rx (.link_clk(link_clk), .pclk(pclk), .dout(dout),
        .lv(lv), .fv(fv), .dual(fmt == ispo_pkg::FMT_DUAL), .lp(lp),
        .ln(ln), .ck(ckp), .nw(), .fw(), .bad(), .edges(), .last());
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // Row sequencing, frame period and exposure gap
    always @(posedge clk) begin
        cyc++;
        if (cyc == 90000) begin
            n_errors++;
            complete_run();
        end
        if (fl) nfl++;
        if (rrs) begin
            chk(rra, 16'(nres % 4));
            nres++;
            if (rra == 16'h0) begin
                if (per_on && t0 > 0) chk(16'(cyc - t0), 16'(FR));
                t0 = cyc;
            end
        end
        if (rds && rda == 16'h0) chk(16'(cyc - t0), 16'(3 * RC));
    end
    task automatic t_serial();
        int e0;
        step(2 * FR);
        chk(16'(rx.nw), 16'h0);
        chk(16'(rx.edges > 0), 16'h1);
        chk(16'(hc), 16'h0);
        e0 = rx.edges;
        fmt = ispo_pkg::FMT_DUAL;
        hcm = 1'b1;
        step(FR);
        chk(16'(hc), 16'h1);
        chk(16'(rx.edges > e0), 16'h1);
        chk(16'(rx.bad), 16'h0);
        $display("test serial done");
    endtask
    task automatic addr_try(input logic s, input logic [7:0] b, input logic e);
        sel = s;
        step(4);
        ab = b;
        stb = 1'b1;
        step(1);
        stb = 1'b0;
        chk(16'(hit), 16'(e));
        step(1);
        chk(16'(hit), 16'h0);
    endtask
    task automatic t_addr();
        addr_try(1'b0, 8'h20, 1'b1);
        addr_try(1'b0, 8'h21, 1'b1);
        addr_try(1'b0, 8'h30, 1'b0);
        addr_try(1'b1, 8'h31, 1'b1);
        addr_try(1'b1, 8'h20, 1'b0);
        $display("test address done");
    endtask
    task automatic t_par();
        pe = 1'b1;
        sd = 1'b1;
        per_on = 1'b1;
        step(2 * FR + 200);
        chk(16'(rx.fw), 16'd32);
        chk(rx.last, 12'h801);
        chk(16'(rx.bad), 16'h0);
        chk(ca, 16'h7);
        chk(16'(oe), 16'h1);
        oen = 1'b1;
        step(100);
        chk(16'(oe), 16'h0);
        dp = 1'b1;
        step(100);
        chk(16'(oe), 16'h1);
        $display("test parallel done");
    endtask
    task automatic t_gain();
        smp = 12'h123;
        aoff = 12'h003;
        ag = 8'h40;
        dg = 8'h40;
        step(2 * FR);
        chk(rx.last, 12'h480);
        $display("test gain done");
    endtask
    task automatic t_stby_trig();
        int n;
        per_on = 1'b0;
        sb = 1'b1;
        step(FR + 300);
        n = nres;
        step(FR);
        chk(16'(nres - n), 16'h0);
        chk(16'(rx.fw), 16'd32);
        tm = 1'b1;
        sb = 1'b0;
        step(FR);
        chk(16'(nres - n), 16'h0);
        nfl = 0;
        trg = 1'b1;
        step(20);
        trg = 1'b0;
        step(FR + 300);
        chk(16'(nres - n), 16'h4);
        chk(16'(nfl), 16'(3 * RC));
        $display("test standby trigger done");
    endtask
    initial begin
        step(8);
        chk(16'({fv, lv, pclk, oe, lp, ckp}), 16'h0);
        step(8);
        rst_n = 1'b1;
        t_serial();
        t_addr();
        t_par();
        t_gain();
        t_stby_trig();
        complete_run();
    end
endmodule
